// [verilog/e1rxs_pkg.sv]
// Constants shared by the E1 receive sync and alarm status block
`default_nettype none
package e1rxs_pkg;
  // ==========================================================
  // Register indexes (byte address is four times the index)
  localparam logic [7:0] IDX_SYNC  = 8'h09;
  localparam logic [7:0] IDX_ALARM = 8'h0a;
  localparam logic [7:0] IDX_MASK  = 8'h18;
  localparam logic [7:0] IDX_CTRL  = 8'h1a;
  localparam int         AW        = 12;

  // ==========================================================
  // Status and control bit positions
  localparam int B_SA1  = 7;
  localparam int B_DMA  = 6;
  localparam int B_SA0  = 5;
  localparam int B_SLIP = 4;
  localparam int B_UA1  = 3;
  localparam int B_RA   = 2;
  localparam int B_CL   = 1;
  localparam int B_LOS  = 0;
  localparam int B_CRC_EN = 0;
  localparam int B_LCL    = 1;

  // ==========================================================
  // Reset values
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [1:0] CTRL_RST = 2'h0;

  // ==========================================================
  // Frame positions
  localparam logic [4:0] TS_ALIGN = 5'h00;
  localparam logic [4:0] TS_SIG   = 5'h10;
  localparam logic [2:0] BP_RA    = 3'h2;
  localparam logic [2:0] BP_DMA   = 3'h5;
  localparam logic [2:0] BP_LAST  = 3'h7;
  localparam logic [3:0] FRM_0    = 4'h0;
  localparam logic [3:0] FRM_LAST = 4'hf;

  // ==========================================================
  // Alarm thresholds
  localparam logic [7:0]  SA1_ZMIN  = 8'h03;
  localparam logic [1:0]  RA_RUN    = 2'h3;
  localparam logic [8:0]  UA1_WLAST = 9'h1ff;
  localparam logic [1:0]  UA1_ZMIN  = 2'h3;
  localparam logic [11:0] CL_SHORT  = 12'h0ff;
  localparam logic [11:0] CL_LONG   = 12'h800;
  localparam logic [7:0]  CL_WLAST  = 8'hfe;
  localparam logic [5:0]  CL_ONES   = 6'h20;

  // Word-aligned address match for a register index
  function automatic logic reg_hit(input logic [AW-1:0] a,
                                   input logic [7:0] idx);
    reg_hit = (a[1:0] == 2'h0) && (a[AW-1:2] == {2'h0, idx});
  endfunction : reg_hit

  // Bit-time position match
  function automatic logic at_pos(input logic [4:0] ts,
                                  input logic [2:0] bp,
                                  input logic [4:0] ts_w,
                                  input logic [2:0] bp_w);
    at_pos = (ts == ts_w) && (bp == bp_w);
  endfunction : at_pos
endpackage : e1rxs_pkg
`default_nettype wire

// [verilog/e1rxs_bit_if.sv]
// Received bit stream and signaling alarm levels between block parts
`timescale 1ns/1ps
`default_nettype none
interface e1rxs_bit_if;
  logic       bit_en;
  logic       data_bit;
  logic [4:0] ts;
  logic [2:0] bpos;
  logic [3:0] frm;
  logic       sa1;
  logic       sa0;
  logic       dma;

  modport src (output bit_en, data_bit, ts, bpos, frm,
               input sa1, sa0, dma);
  modport mon (input bit_en, data_bit, ts, bpos, frm,
               output sa1, sa0, dma);
endinterface : e1rxs_bit_if
`default_nettype wire

// [verilog/e1rxs_ts16_mon.sv]
// Time slot 16 monitor: signaling all ones, all zeros, distant MF alarm
`timescale 1ns/1ps
`default_nettype none
module e1rxs_ts16_mon
  import e1rxs_pkg::*;
(
  input  wire logic clock,
  input  wire logic sys_rst,
  e1rxs_bit_if.mon  bi
);
  // ==========================================================
  // Position decode
  wire       in_sig  = bi.bit_en && (bi.ts == TS_SIG);
  wire       mf_end  = in_sig && (bi.frm == FRM_LAST) &&
                       (bi.bpos == BP_LAST);
  wire       dma_pos = bi.bit_en && (bi.frm == FRM_0) &&
                       at_pos(bi.ts, bi.bpos, TS_SIG, BP_DMA);
  wire [7:0] z_inc   = {7'h00, ~bi.data_bit};
  wire [7:0] o_inc   = {7'h00, bi.data_bit};

  logic [7:0] zeros_r;
  logic [7:0] ones_r;
  logic       sa1_r;
  logic       sa0_r;
  logic       dma_r;
  logic       dma_prev_r;

  wire [7:0] z_now = zeros_r + z_inc;
  wire [7:0] o_now = ones_r + o_inc;

  // ==========================================================
  // Multiframe zero and one counts
  always_ff @(posedge clock) begin
    if (sys_rst || mf_end) begin
      zeros_r <= 8'h00;
      ones_r  <= 8'h00;
    end else if (in_sig) begin
      zeros_r <= z_now;
      ones_r  <= o_now;
    end
  end

  // Alarm verdicts once per multiframe, also in CCS mode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sa1_r <= 1'b0;
      sa0_r <= 1'b0;
    end else if (mf_end) begin
      sa1_r <= (z_now < SA1_ZMIN);
      sa0_r <= (o_now == 8'h00);
    end
  end

  // Two multiframes in a row agree before the alarm moves
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dma_r      <= 1'b0;
      dma_prev_r <= 1'b0;
    end else if (dma_pos) begin
      dma_prev_r <= bi.data_bit;
      if (bi.data_bit && dma_prev_r)
        dma_r <= 1'b1;
      else if (!bi.data_bit && !dma_prev_r)
        dma_r <= 1'b0;
    end
  end

  assign bi.sa1 = sa1_r;
  assign bi.sa0 = sa0_r;
  assign bi.dma = dma_r;
endmodule : e1rxs_ts16_mon
`default_nettype wire

// [verilog/e1rxs_top.sv]
// E1 receive synchronizer status, alarm detection and status registers
`timescale 1ns/1ps
`default_nettype none
module e1rxs_top
  import e1rxs_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          sys_rst,
  input  wire logic [AW-1:0] paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          rx_bit_en,
  input  wire logic          rx_positive_in,
  input  wire logic          rx_negative_in,
  input  wire logic          rx_data_bit,
  input  wire logic [4:0]    rx_ts_index,
  input  wire logic [2:0]    rx_bit_pos,
  input  wire logic [3:0]    rx_frame_index,
  input  wire logic          rx_frame_nonalign,
  input  wire logic          frame_align_hunting,
  input  wire logic          sig_multiframe_hunting,
  input  wire logic          crc_multiframe_hunting,
  input  wire logic          crc_mf_locked,
  input  wire logic          crc_search_timeout,
  input  wire logic          rx_in_sync,
  input  wire logic          es_frame_repeat,
  input  wire logic          es_frame_delete,
  input  wire logic          sig_change,
  output logic               crc_mode_enable,
  output logic               int_n
);
  // ==========================================================
  // Time slot 16 monitor
  e1rxs_bit_if bits ();

  assign bits.bit_en   = rx_bit_en;
  assign bits.data_bit = rx_data_bit;
  assign bits.ts       = rx_ts_index;
  assign bits.bpos     = rx_bit_pos;
  assign bits.frm      = rx_frame_index;

  e1rxs_ts16_mon u_ts16 (
    .clock   (clock),
    .sys_rst (sys_rst),
    .bi      (bits.mon)
  );

  // ==========================================================
  // Register bus decode
  logic [7:0] mask_r;
  logic [1:0] ctrl_r;
  logic [7:0] prdata_r;
  logic       slverr_r;

  wire setup    = psel && !penable;
  wire access   = psel && penable;
  wire hit_sync = reg_hit(paddr, IDX_SYNC);
  wire hit_alm  = reg_hit(paddr, IDX_ALARM);
  wire hit_mask = reg_hit(paddr, IDX_MASK);
  wire hit_ctrl = reg_hit(paddr, IDX_CTRL);
  wire hit_any  = hit_sync || hit_alm || hit_mask || hit_ctrl;
  wire wr_mask  = access && pwrite && hit_mask;
  wire wr_ctrl  = access && pwrite && hit_ctrl;
  wire rd_alm   = access && !pwrite && hit_alm;
  wire long_cl  = ctrl_r[B_LCL];

  assign crc_mode_enable = ctrl_r[B_CRC_EN];

  // ==========================================================
  // Resync counter
  logic [5:0] resync_r;
  logic [5:0] resync_nxt;

  always_comb begin
    resync_nxt = resync_r;
    if (!crc_mode_enable || crc_mf_locked)
      resync_nxt = 6'h00;
    else if (crc_search_timeout)
      resync_nxt = resync_r + 6'h01;
  end

  always_ff @(posedge clock) begin
    if (sys_rst)
      resync_r <= 6'h00;
    else
      resync_r <= resync_nxt;
  end

  // Live synchronizer view, nothing latched
  wire [7:0] sync_view = {resync_r[5:2], resync_r[0],
                          frame_align_hunting,
                          sig_multiframe_hunting,
                          crc_multiframe_hunting};

  // ==========================================================
  // Unframed all ones over 512-bit windows
  logic [8:0] ua_win_r;
  logic [1:0] ua_zero_r;
  logic       ua1_r;

  wire ua_end  = rx_bit_en && (ua_win_r == UA1_WLAST);
  wire ua_zsat = (ua_zero_r == UA1_ZMIN);
  wire [1:0] ua_znow = ua_zsat ? ua_zero_r :
                       ua_zero_r + {1'b0, ~rx_data_bit};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ua_win_r  <= 9'h000;
      ua_zero_r <= 2'h0;
    end else if (rx_bit_en) begin
      ua_win_r  <= ua_win_r + 9'h001;
      ua_zero_r <= ua_end ? 2'h0 : ua_znow;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst)
      ua1_r <= 1'b0;
    else if (ua_end)
      ua1_r <= (ua_znow < UA1_ZMIN);
  end

  // ==========================================================
  // Remote alarm from nonalign frame bit 3
  logic [1:0] ra_ones_r;
  logic [1:0] ra_zeros_r;
  logic       ra_r;

  wire ra_pos = rx_bit_en && rx_frame_nonalign &&
                at_pos(rx_ts_index, rx_bit_pos, TS_ALIGN, BP_RA);
  wire [1:0] ra_o_nxt = (ra_ones_r == RA_RUN) ? RA_RUN :
                        ra_ones_r + 2'h1;
  wire [1:0] ra_z_nxt = (ra_zeros_r == RA_RUN) ? RA_RUN :
                        ra_zeros_r + 2'h1;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ra_ones_r  <= 2'h0;
      ra_zeros_r <= 2'h0;
    end else if (ra_pos) begin
      ra_ones_r  <= rx_data_bit ? ra_o_nxt : 2'h0;
      ra_zeros_r <= rx_data_bit ? 2'h0 : ra_z_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst)
      ra_r <= 1'b0;
    else if (ra_ones_r == RA_RUN)
      ra_r <= 1'b1;
    else if (ra_zeros_r == RA_RUN)
      ra_r <= 1'b0;
  end

  // ==========================================================
  // Carrier loss from line pulses
  logic [11:0] cl_run_r;
  logic [7:0]  cl_win_r;
  logic [5:0]  cl_ones_r;
  logic        cl_r;

  wire        line_one = rx_positive_in || rx_negative_in;
  wire [11:0] cl_limit = long_cl ? CL_LONG : CL_SHORT;
  wire        cl_hit   = rx_bit_en && !line_one &&
                         (cl_run_r + 12'h001 >= cl_limit);
  wire        cl_wend  = rx_bit_en && (cl_win_r == CL_WLAST);
  wire        cl_osat  = (cl_ones_r == CL_ONES);
  wire [5:0]  cl_onow  = (cl_osat || !line_one) ? cl_ones_r :
                         cl_ones_r + 6'h01;

  always_ff @(posedge clock) begin
    if (sys_rst)
      cl_run_r <= 12'h000;
    else if (rx_bit_en && line_one)
      cl_run_r <= 12'h000;
    else if (rx_bit_en && (cl_run_r != CL_LONG))
      cl_run_r <= cl_run_r + 12'h001;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cl_win_r  <= 8'h00;
      cl_ones_r <= 6'h00;
    end else if (rx_bit_en) begin
      cl_win_r  <= cl_wend ? 8'h00 : cl_win_r + 8'h01;
      cl_ones_r <= cl_wend ? 6'h00 : cl_onow;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst)
      cl_r <= 1'b0;
    else if (cl_hit)
      cl_r <= 1'b1;
    else if (cl_wend && (cl_onow >= CL_ONES))
      cl_r <= 1'b0;
  end

  // ==========================================================
  // Status bits and pending flags
  logic [7:0] lvl_d_r;
  logic [7:0] ev_r;
  logic [7:0] pend_r;

  wire [7:0] lvl;
  wire [7:0] ev_set;
  wire [7:0] trig;
  wire [7:0] alm_view;

  assign lvl[B_SA1]  = bits.sa1;
  assign lvl[B_DMA]  = bits.dma;
  assign lvl[B_SA0]  = bits.sa0;
  assign lvl[B_SLIP] = 1'b0;
  assign lvl[B_UA1]  = ua1_r;
  assign lvl[B_RA]   = ra_r;
  assign lvl[B_CL]   = cl_r;
  assign lvl[B_LOS]  = !rx_in_sync;

  wire [7:0] lvl_rise = lvl & ~lvl_d_r;

  // Signaling all ones and all zeros fire on detection and on each signaling change, DMA on detection only; slips on each one
  assign ev_set[B_SA1]  = lvl_rise[B_SA1] || sig_change;
  assign ev_set[B_DMA]  = lvl_rise[B_DMA];
  assign ev_set[B_SA0]  = lvl_rise[B_SA0] || sig_change;
  assign ev_set[B_SLIP] = es_frame_repeat ||
                          es_frame_delete;
  assign ev_set[3:0]    = 4'h0;

  // Alarm bits trigger on either edge, event bits on the event
  assign trig = {ev_set[7:4],
                 lvl[3:0] ^ lvl_d_r[3:0]};

  assign alm_view = {ev_r[7:4] | lvl[7:4], lvl[3:0]};

  always_ff @(posedge clock) begin
    if (sys_rst)
      lvl_d_r <= 8'h00;
    else
      lvl_d_r <= lvl;
  end

  // ==========================================================
  // Read release: only flags already set when the data was taken
  // A change that lands on the setup edge stays pending for the next read
  logic [7:0] seen_r;
  wire  [7:0] rd_clr = {8{rd_alm}} & seen_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      seen_r <= 8'h00;
    end else if (setup) begin
      seen_r <= pend_r;
    end
  end

  // Set wins over a read clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          ev_r[gi]   <= 1'b0;
          pend_r[gi] <= 1'b0;
        end else begin
          ev_r[gi]   <= ev_set[gi] ||
                        (ev_r[gi] && !rd_clr[gi]);
          pend_r[gi] <= trig[gi] ||
                        (pend_r[gi] && !rd_clr[gi]);
        end
      end
    end
  endgenerate

  assign int_n = ~|(pend_r & mask_r);

  // ==========================================================
  // Writable registers
  always_ff @(posedge clock) begin
    if (sys_rst)
      mask_r <= MASK_RST;
    else if (wr_mask)
      mask_r <= pwdata[7:0];
  end

  always_ff @(posedge clock) begin
    if (sys_rst)
      ctrl_r <= CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= pwdata[1:0];
  end

  // ==========================================================
  // Read data captured in the setup cycle
  wire [7:0] rd_mux = hit_sync ? sync_view :
                      hit_alm  ? alm_view :
                      hit_mask ? mask_r :
                      hit_ctrl ? {6'h00, ctrl_r} : 8'h00;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata_r <= 8'h00;
      slverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= rd_mux;
      slverr_r <= !hit_any;
    end
  end

  assign prdata  = {24'h000000, prdata_r};
  assign pready  = 1'b1;
  assign pslverr = access && slverr_r;
endmodule : e1rxs_top
`default_nettype wire

// [tb/e1rxs_top_asserts.sv]
// Port checker for the E1 receive sync and alarm status block
`timescale 1ns/1ps
`default_nettype none
module e1rxs_top_asserts
  import e1rxs_pkg::*;
(
  input wire logic          clock,
  input wire logic          sys_rst,
  input wire logic [AW-1:0] paddr,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          frame_align_hunting,
  input wire logic          sig_multiframe_hunting,
  input wire logic          crc_multiframe_hunting,
  input wire logic          rx_in_sync,
  input wire logic          es_frame_repeat,
  input wire logic          sig_change,
  input wire logic          crc_mode_enable,
  input wire logic          int_n
);
  // ==========================================================
  // Mask shadow built from bus writes
  logic [7:0] mask_r;
  wire        acc = psel && penable;
  wire        mapped = paddr == 12'h024 || paddr == 12'h028 || paddr == 12'h060
                       || paddr == 12'h068;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mask_r <= MASK_RST;
    end else if (acc && pwrite && paddr == 12'h060) begin
      mask_r <= pwdata[7:0];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_setup(logic [AW-1:0] a);
    psel && !penable && paddr == a;
  endsequence

  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (acc |-> pslverr == !mapped)
    else $error("pslverr does not follow address decode");
  a_sync_live: assert property (s_setup(12'h024) |=>
    prdata[2:0] == $past({frame_align_hunting, sig_multiframe_hunting, crc_multiframe_hunting}))
    else $error("sync hunting bits not live");
  a_count_held: assert property (s_setup(12'h024) ##0 !crc_mode_enable
    && !$past(crc_mode_enable) |=> prdata[7:3] == 5'h00)
    else $error("resync count not zero with crc mode off");
  a_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_los_read: assert property (s_setup(12'h028) ##0 $stable(rx_in_sync)
    && !$past(sys_rst) |=> prdata[B_LOS] == !$past(rx_in_sync))
    else $error("loss of sync bit wrong");
  a_slip_irq: assert property (es_frame_repeat |=> !mask_r[B_SLIP] || !int_n)
    else $error("slip did not interrupt");
  a_sig_irq: assert property (sig_change |=> !(mask_r[B_SA1] || mask_r[B_SA0]) || !int_n)
    else $error("signaling change did not interrupt");
  a_masked_quiet: assert property (mask_r == 8'h00 |-> int_n)
    else $error("interrupt with all sources masked");
  a_ctrl_write: assert property (acc && pwrite && paddr == 12'h068
    |=> crc_mode_enable == $past(pwdata[B_CRC_EN]))
    else $error("crc mode output not written");
endmodule : e1rxs_top_asserts

bind e1rxs_top e1rxs_top_asserts i_chk (.clock, .sys_rst, .paddr, .psel, .penable, .pwrite,
  .pwdata, .prdata, .pready, .pslverr, .frame_align_hunting, .sig_multiframe_hunting,
  .crc_multiframe_hunting, .rx_in_sync, .es_frame_repeat, .sig_change, .crc_mode_enable, .int_n);
`default_nettype wire

// [tb/e1rxs_line_model.sv]
// Behavioural E1 line: bit timing, frame position and line pulses
`timescale 1ns/1ps
`default_nettype none
module e1rxs_line_model (
  input  wire logic  clock,
  input  wire logic  line_rst,
  input  wire logic  ones,
  output logic       rx_bit_en,
  output logic       rx_data_bit,
  output logic       rx_positive_in,
  output logic       rx_negative_in,
  output logic [4:0] rx_ts_index,
  output logic [2:0] rx_bit_pos,
  output logic [3:0] rx_frame_index,
  output logic       rx_frame_nonalign
);
  logic        ph_r;
  logic        pol_r;
  logic [11:0] pos_r;

  // Position is {frame, slot, bit}; odd frames are non-alignment frames
  assign {rx_frame_index, rx_ts_index, rx_bit_pos} = pos_r;
  assign rx_frame_nonalign = pos_r[8];
  assign rx_positive_in = rx_data_bit && pol_r;
  assign rx_negative_in = rx_data_bit && !pol_r;

  always_ff @(posedge clock) begin
    if (line_rst) begin
      ph_r <= 1'b0;
      pol_r <= 1'b0;
      pos_r <= 12'hfff;
      rx_bit_en <= 1'b0;
      rx_data_bit <= 1'b0;
    end else begin
      ph_r <= !ph_r;
      rx_bit_en <= ph_r;
      if (ph_r) begin
        pos_r <= pos_r + 12'h001;
        rx_data_bit <= ones;
        pol_r <= pol_r ^ ones;
      end
    end
  end
endmodule : e1rxs_line_model
`default_nettype wire

// [tb/e1rxs_top_tb.sv]
// Self-checking bench for the E1 receive sync and alarm status block
`timescale 1ns/1ps
`default_nettype none
module e1rxs_top_tb
  import e1rxs_pkg::*;
;
  logic        clock, sys_rst, psel, penable, pwrite, crc_mf_locked, rx_in_sync, ones, line_rst;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [2:0]  hunt;
  logic [3:0]  pls;
  logic [7:0]  d;
  logic        e;
  wire  [31:0] prdata;
  wire         pready, pslverr, crc_mode_enable, int_n, rx_bit_en, rx_data_bit;
  wire         rx_positive_in, rx_negative_in, rx_frame_nonalign;
  wire  [4:0]  rx_ts_index;
  wire  [2:0]  rx_bit_pos;
  wire  [3:0]  rx_frame_index;
  int          n_fail, checked;

  e1rxs_top i_dut (.clock, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .rx_bit_en, .rx_positive_in, .rx_negative_in, .rx_data_bit,
    .rx_ts_index, .rx_bit_pos, .rx_frame_index, .rx_frame_nonalign,
    .frame_align_hunting(hunt[2]), .sig_multiframe_hunting(hunt[1]),
    .crc_multiframe_hunting(hunt[0]), .crc_mf_locked, .crc_search_timeout(pls[0]),
    .rx_in_sync, .es_frame_repeat(pls[1]), .es_frame_delete(pls[2]), .sig_change(pls[3]),
    .crc_mode_enable, .int_n);

  e1rxs_line_model i_line (.clock, .line_rst, .ones, .rx_bit_en, .rx_data_bit,
    .rx_positive_in, .rx_negative_in, .rx_ts_index, .rx_bit_pos, .rx_frame_index,
    .rx_frame_nonalign);

  always #10 clock = !clock;

  // ==========================================================
  // Shared tasks
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    checked++;
    if (got !== ex) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
    int   n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge clock);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      d = prdata[7:0];
      e = pslverr;
      if (pready === 1'b1) break;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      n_fail++;
      complete_run();
    end
    @(posedge clock);
  endtask : apb

  task automatic rd(input logic [11:0] a, input string nm, input logic [7:0] ex,
                    input logic [7:0] m);
    apb(1'b0, a, 8'h00);
    chk(nm, ex, d & m);
  endtask : rd

  task automatic pulse(input int i);
    pls[i] <= 1'b1;
    @(posedge clock);
    pls[i] <= 1'b0;
  endtask : pulse

  task automatic irq(input string nm, input logic ex);
    @(negedge clock);
    chk(nm, {7'h0, ex}, {7'h0, int_n});
    @(posedge clock);
  endtask : irq

  task automatic tmo(input int n);
    for (int i = 0; i < n; i++) begin
      pulse(0);
      @(posedge clock);
    end
  endtask : tmo

  task automatic bits(input int n);
    repeat (2 * n) @(posedge clock);
  endtask : bits

  function automatic logic [7:0] cf(input logic [5:0] c);
    cf = {c[5:2], c[0], 3'h0};
  endfunction : cf

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rd(12'h024, "sync reset", 8'h00, 8'hff);
    rd(12'h028, "alarm reset", 8'h00, 8'hff);
    rd(12'h060, "mask reset", MASK_RST, 8'hff);
    rd(12'h068, "ctrl reset", {6'h0, CTRL_RST}, 8'hff);
    chk("mapped err", 8'h00, {7'h0, e});
    apb(1'b0, 12'h02c, 8'h00);
    chk("unmapped err", 8'h01, {7'h0, e});
    apb(1'b0, 12'h025, 8'h00);
    chk("misaligned err", 8'h01, {7'h0, e});
    apb(1'b1, 12'h024, 8'hff);
    rd(12'h024, "sync after write", 8'h00, 8'hff);
    for (int k = 0; k < 8; k++) begin
      hunt <= k[2:0];
      rd(12'h024, "hunting bits", k[7:0], 8'h07);
    end
    hunt <= 3'h0;
  endtask : t_regs

  task automatic t_count;
    apb(1'b1, 12'h068, 8'h01);
    chk("crc mode on", 8'h01, {7'h0, crc_mode_enable});
    tmo(5);
    rd(12'h024, "count 5", cf(6'h05), 8'hf8);
    tmo(63);
    rd(12'h024, "count wrap", cf(6'h04), 8'hf8);
    crc_mf_locked <= 1'b1;
    @(posedge clock);
    crc_mf_locked <= 1'b0;
    rd(12'h024, "count locked", 8'h00, 8'hf8);
    tmo(3);
    rd(12'h024, "count 3", cf(6'h03), 8'hf8);
    apb(1'b1, 12'h068, 8'h00);
    rd(12'h024, "count crc off", 8'h00, 8'hf8);
    chk("crc mode off", 8'h00, {7'h0, crc_mode_enable});
  endtask : t_count

  task automatic t_irq;
    apb(1'b1, 12'h060, 8'h10);
    for (int i = 1; i < 3; i++) begin
      pulse(i);
      irq("slip irq", 1'b0);
      rd(12'h028, "slip bit", 8'h10, 8'h10);
      irq("slip released", 1'b1);
    end
    apb(1'b1, 12'h060, 8'h00);
    pulse(1);
    irq("slip masked", 1'b1);
    rd(12'h028, "slip masked bit", 8'h10, 8'h10);
    apb(1'b1, 12'h060, 8'ha1);
    pulse(3);
    irq("sig change irq", 1'b0);
    rd(12'h028, "sig change bits", 8'ha0, 8'ha0);
    irq("sig released", 1'b1);
    rx_in_sync <= 1'b0;
    bits(2);
    irq("los irq", 1'b0);
    rd(12'h028, "los bit", 8'h01, 8'h01);
    irq("los released", 1'b1);
    rx_in_sync <= 1'b1;
    bits(2);
    irq("los clear irq", 1'b0);
    rd(12'h028, "los cleared", 8'h00, 8'h01);
    apb(1'b1, 12'h060, 8'h00);
  endtask : t_irq

  task automatic t_line;
    apb(1'b1, 12'h068, 8'h02);
    line_rst <= 1'b0;
    bits(300);
    rd(12'h028, "long cl early", 8'h00, 8'h02);
    bits(1800);
    rd(12'h028, "long cl set", 8'h02, 8'h02);
    ones <= 1'b1;
    bits(12288);
    rd(12'h028, "live alarms", 8'h0c, 8'h0f);
    rd(12'h028, "all ones", 8'hcc, 8'hff);
    apb(1'b1, 12'h068, 8'h00);
    ones <= 1'b0;
    bits(200);
    rd(12'h028, "short cl early", 8'h00, 8'h02);
    bits(100);
    rd(12'h028, "short cl set", 8'h02, 8'h02);
    bits(12288);
    rd(12'h028, "live alarms", 8'h02, 8'h0f);
    rd(12'h028, "all zeros", 8'h22, 8'hff);
  endtask : t_line

  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    hunt = 3'h0;
    pls = 4'h0;
    crc_mf_locked = 1'b0;
    rx_in_sync = 1'b1;
    ones = 1'b0;
    line_rst = 1'b1;
    n_fail = 0;
    checked = 0;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_count();
    t_irq();
    t_line();
    complete_run();
  end
endmodule : e1rxs_top_tb
`default_nettype wire
